/* common/scg_defines.vh */
// constants for the sleep and clock gating block
`ifndef SCG_DEFINES_VH
`define SCG_DEFINES_VH

// register addresses
`define SCG_ADDR_W 2
`define SCG_ADDR_SLEEP_CTRL 2'h0
`define SCG_ADDR_GATE_0 2'h1
`define SCG_ADDR_GATE_1 2'h2
`define SCG_ADDR_ANALOG_CTRL 2'h3

// sleep control fields
`define SCG_SLEEP_ALLOW_BIT 0
`define SCG_SLEEP_SEL_LSB 1
`define SCG_SLEEP_CTRL_MASK 8'h0f

// gate register 0 fields
`define SCG_G0_TWO_WIRE 7
`define SCG_G0_TIMER_ZERO 5
`define SCG_G0_TIMER_ONE 3
`define SCG_G0_SERIAL_PERIPH 2
`define SCG_G0_CONVERTER 0
`define SCG_G0_MASK 8'had

// gate register 1 fields
`define SCG_G1_USB 7
`define SCG_G1_TIMER_FOUR 4
`define SCG_G1_TIMER_THREE 3
`define SCG_G1_SERIAL_PORT_ONE 0
`define SCG_G1_MASK 8'h99

// analog control fields
`define SCG_AN_CONV_EN 0
`define SCG_AN_COMP_EN 1
`define SCG_AN_COMP_REF 2
`define SCG_AN_MASK 8'h07

// reset values
`define SCG_RST_VAL 8'h00

// sleep select codes
`define SCG_MODE_IDLE 3'h0
`define SCG_MODE_QUIET 3'h1
`define SCG_MODE_PDOWN 3'h2
`define SCG_MODE_PSAVE 3'h3
`define SCG_MODE_RSV4 3'h4
`define SCG_MODE_RSV5 3'h5
`define SCG_MODE_STBY 3'h6
`define SCG_MODE_XSTBY 3'h7

// standby wake-up latency in clock cycles
`define SCG_STBY_WAKE_CYC 3'h6

`endif

/* rtl/scg_sleep_gate.v */
// sleep mode decode, wake-up and per-peripheral clock gating
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.vh"

module scg_sleep_gate (
	// clock and reset
	input wire i_ref_clk,
	input wire i_srst,
	// register port
	input wire [`SCG_ADDR_W-1:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	// core side
	input wire i_sleep_instr,
	input wire i_crystal_src,
	// wake sources
	input wire i_wk_ext_lines_low,
	input wire i_wk_ext_line_six,
	input wire i_ext_line_six_level,
	input wire i_wk_pin_change,
	input wire i_wk_two_wire_match,
	input wire i_wk_mem_ready,
	input wire i_wk_converter,
	input wire i_wk_watch_timer,
	input wire i_wk_other_io,
	input wire i_wk_usb_sync,
	input wire i_bus_voltage_change_irq,
	input wire i_usb_wake_irq,
	// status and clock enables
	output reg o_sleeping,
	output reg o_core_clk_en,
	output reg o_io_clk_en,
	output reg o_converter_clk_en,
	output reg o_main_osc_en,
	output reg [7:0] o_gate0_clk_en,
	output reg [7:0] o_gate1_clk_en,
	// analog side effects
	output reg o_converter_en,
	output reg o_converter_extended,
	output reg o_comparator_en,
	output reg o_comparator_mux_ok,
	output reg o_int_ref_en
);

	localparam ST_RUN = 2'h0;
	localparam ST_SLEEP = 2'h1;
	localparam ST_RESUME = 2'h2;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [2:0] mode_reg;
	reg [2:0] wait_reg;
	reg [2:0] wait_next;
	reg sleep_allow_reg;
	reg [2:0] sleep_select_reg;
	reg [7:0] peripheral_clock_gate_0_reg;
	reg [7:0] peripheral_clock_gate_1_reg;
	reg [7:0] analog_reg;
	reg conv_was_off_reg;
	reg wake;
	reg [2:0] eff_mode;
	reg keep_io;
	reg keep_conv;
	reg keep_main;
	reg sleep_now;
	reg [7:0] rd_mux;
	reg [7:0] g0_en;
	reg [7:0] g1_en;
	reg comp_on;
	reg [2:0] mode_next;
	reg sleep_allow_next;
	reg [2:0] sleep_select_next;
	reg [7:0] peripheral_clock_gate_0_next;
	reg [7:0] peripheral_clock_gate_1_next;
	reg [7:0] analog_next;
	reg conv_was_off_next;
	wire [7:0] g0_mask;
	wire [7:0] g1_mask;
	wire [7:0] g0_bit;
	wire [7:0] g1_bit;

	assign g0_mask = `SCG_G0_MASK;
	assign g1_mask = `SCG_G1_MASK;

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	always @* begin
		// standby codes need a crystal source; else treated as power-down
		eff_mode = sleep_select_reg;
		if ((sleep_select_reg == `SCG_MODE_STBY || sleep_select_reg == `SCG_MODE_XSTBY)
			&& !i_crystal_src) begin
			eff_mode = `SCG_MODE_PDOWN;
		end
	end

	always @* begin
		keep_io = 1'b1;
		keep_conv = 1'b1;
		keep_main = 1'b1;
		// domains follow the next state so they switch with the sleep flag
		if (state_next != ST_RUN) begin
			case (mode_next)
				`SCG_MODE_IDLE: begin
					keep_io = 1'b1;
				end
				`SCG_MODE_QUIET: begin
					keep_io = 1'b0;
				end
				`SCG_MODE_STBY, `SCG_MODE_XSTBY: begin
					keep_io = 1'b0;
					keep_conv = 1'b0;
				end
				default: begin
					keep_io = 1'b0;
					keep_conv = 1'b0;
					keep_main = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// wake decode
	// ------------------------------------------------------------
	always @* begin
		// asynchronous usb sources wake in every mode
		wake = i_bus_voltage_change_irq | i_usb_wake_irq;
		wake = wake | i_wk_ext_lines_low | i_wk_pin_change;
		wake = wake | i_wk_two_wire_match | i_wk_watch_timer;
		case (mode_reg)
			`SCG_MODE_IDLE: begin
				wake = wake | i_wk_ext_line_six | i_wk_mem_ready | i_wk_converter
					| i_wk_other_io | i_wk_usb_sync;
			end
			`SCG_MODE_QUIET: begin
				wake = wake | (i_wk_ext_line_six & i_ext_line_six_level) | i_wk_mem_ready
					| i_wk_converter | i_wk_usb_sync;
			end
			default: begin
				wake = wake | (i_wk_ext_line_six & i_ext_line_six_level);
			end
		endcase
	end

	// ------------------------------------------------------------
	// sleep state machine
	// ------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		wait_next = wait_reg;
		mode_next = mode_reg;
		sleep_now = i_sleep_instr & sleep_allow_reg &
			(sleep_select_reg != `SCG_MODE_RSV4) & (sleep_select_reg != `SCG_MODE_RSV5);
		case (state_reg)
			ST_RUN: begin
				if (sleep_now) begin
					state_next = ST_SLEEP;
					mode_next = eff_mode;
				end
			end
			ST_SLEEP: begin
				if (wake) begin
					if (mode_reg == `SCG_MODE_STBY || mode_reg == `SCG_MODE_XSTBY) begin
						state_next = ST_RESUME;
						wait_next = `SCG_STBY_WAKE_CYC - 3'h1;
					end else begin
						state_next = ST_RUN;
					end
				end
			end
			ST_RESUME: begin
				if (wait_reg == 3'h0) begin
					state_next = ST_RUN;
				end else begin
					wait_next = wait_reg - 3'h1;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// ------------------------------------------------------------
	// gated clock enables
	// ------------------------------------------------------------
	genvar gb;
	generate
		for (gb = 0; gb < 8; gb = gb + 1) begin : gen_gate
			// in deeper sleep the io clock is off whatever the gate bits say
			assign g0_bit[gb] = keep_io & ~peripheral_clock_gate_0_reg[gb] & g0_mask[gb];
			assign g1_bit[gb] = keep_io & ~peripheral_clock_gate_1_reg[gb] & g1_mask[gb];
		end
	endgenerate

	always @* begin
		g0_en = g0_bit;
		g1_en = g1_bit;
		// converter runs on its own clock in quiet mode
		g0_en[`SCG_G0_CONVERTER] = keep_conv & ~peripheral_clock_gate_0_reg[`SCG_G0_CONVERTER];
	end

	// ------------------------------------------------------------
	// analog side effects
	// ------------------------------------------------------------
	always @* begin
		// comparator is forced off as soon as the next state is a deep sleep
		comp_on = analog_reg[`SCG_AN_COMP_EN] &
			((mode_next == `SCG_MODE_IDLE) || (mode_next == `SCG_MODE_QUIET) ||
			(state_next == ST_RUN));
		// extended flag set while off, cleared by a finished conversion; set wins
		conv_was_off_next = conv_was_off_reg;
		if (!analog_reg[`SCG_AN_CONV_EN]) begin
			conv_was_off_next = 1'b1;
		end else if (i_wk_converter) begin
			conv_was_off_next = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// read mux with reserved bit positions masked to zero
	// ------------------------------------------------------------
	always @* begin
		case (i_addr)
			`SCG_ADDR_SLEEP_CTRL: rd_mux = {4'h0, sleep_select_reg, sleep_allow_reg};
			`SCG_ADDR_GATE_0: rd_mux = peripheral_clock_gate_0_reg & `SCG_G0_MASK;
			`SCG_ADDR_GATE_1: rd_mux = peripheral_clock_gate_1_reg & `SCG_G1_MASK;
			`SCG_ADDR_ANALOG_CTRL: rd_mux = analog_reg & `SCG_AN_MASK;
			default: rd_mux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always @* begin
		sleep_allow_next = sleep_allow_reg;
		sleep_select_next = sleep_select_reg;
		peripheral_clock_gate_0_next = peripheral_clock_gate_0_reg;
		peripheral_clock_gate_1_next = peripheral_clock_gate_1_reg;
		analog_next = analog_reg;
		if (i_wr) begin
			case (i_addr)
				`SCG_ADDR_SLEEP_CTRL: begin
					sleep_allow_next = i_wdata[`SCG_SLEEP_ALLOW_BIT];
					sleep_select_next = i_wdata[`SCG_SLEEP_SEL_LSB+2:`SCG_SLEEP_SEL_LSB];
				end
				`SCG_ADDR_GATE_0: begin
					// reserved positions never store a one
					peripheral_clock_gate_0_next = i_wdata & `SCG_G0_MASK;
				end
				`SCG_ADDR_GATE_1: begin
					peripheral_clock_gate_1_next = i_wdata & `SCG_G1_MASK;
				end
				`SCG_ADDR_ANALOG_CTRL: begin
					analog_next = i_wdata & `SCG_AN_MASK;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_reg <= ST_RUN;
			mode_reg <= `SCG_MODE_IDLE;
			wait_reg <= 3'h0;
			sleep_allow_reg <= 1'b0;
			sleep_select_reg <= 3'h0;
			peripheral_clock_gate_0_reg <= `SCG_RST_VAL;
			peripheral_clock_gate_1_reg <= `SCG_RST_VAL;
			analog_reg <= `SCG_RST_VAL;
			conv_was_off_reg <= 1'b1;
			o_rdata <= 8'h00;
			o_sleeping <= 1'b0;
			o_core_clk_en <= 1'b1;
			o_io_clk_en <= 1'b1;
			o_converter_clk_en <= 1'b1;
			o_main_osc_en <= 1'b1;
			o_gate0_clk_en <= `SCG_G0_MASK;
			o_gate1_clk_en <= `SCG_G1_MASK;
			o_converter_en <= 1'b0;
			o_converter_extended <= 1'b1;
			o_comparator_en <= 1'b0;
			o_comparator_mux_ok <= 1'b1;
			o_int_ref_en <= 1'b0;
		end else begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			mode_reg <= mode_next;
			sleep_allow_reg <= sleep_allow_next;
			sleep_select_reg <= sleep_select_next;
			peripheral_clock_gate_0_reg <= peripheral_clock_gate_0_next;
			peripheral_clock_gate_1_reg <= peripheral_clock_gate_1_next;
			analog_reg <= analog_next;
			conv_was_off_reg <= conv_was_off_next;
			o_rdata <= i_rd ? rd_mux : 8'h00;
			o_sleeping <= (state_next != ST_RUN);
			// registered enables give clean clock gating
			o_core_clk_en <= (state_next == ST_RUN);
			o_io_clk_en <= keep_io;
			o_converter_clk_en <= keep_conv;
			o_main_osc_en <= keep_main;
			o_gate0_clk_en <= g0_en;
			o_gate1_clk_en <= g1_en;
			// converter enable is untouched by sleep
			o_converter_en <= analog_reg[`SCG_AN_CONV_EN];
			o_converter_extended <= conv_was_off_reg;
			o_comparator_en <= comp_on;
			o_comparator_mux_ok <= ~peripheral_clock_gate_0_reg[`SCG_G0_CONVERTER];
			o_int_ref_en <= analog_reg[`SCG_AN_COMP_EN] & analog_reg[`SCG_AN_COMP_REF];
		end
	end

endmodule
`default_nettype wire

/* tb/scg_checker_properties.sv */
// assertions for the sleep and clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.vh"
module scg_checker (
	// watched ports
	input wire logic i_ref_clk, i_srst, i_wr, i_rd, i_sleep_instr, i_crystal_src,
	input wire logic i_usb_wake_irq, i_bus_voltage_change_irq, o_sleeping, o_core_clk_en,
	input wire logic o_io_clk_en, o_converter_clk_en, o_main_osc_en, o_converter_en,
	input wire logic o_comparator_en, o_comparator_mux_ok, o_int_ref_en,
	input wire logic [`SCG_ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata, o_rdata, o_gate1_clk_en
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);
	logic [3:0] ctrl_reg;
	logic [2:0] sel;
	logic [2:0] dom;
	assign sel = ctrl_reg[3:1];
	assign dom = {o_io_clk_en, o_converter_clk_en, o_main_osc_en};
	// shadow of the sleep control register
	always @(posedge i_ref_clk)
		if (i_srst)
			ctrl_reg <= 4'h0;
		else if (i_wr && i_addr == `SCG_ADDR_SLEEP_CTRL)
			ctrl_reg <= i_wdata[3:0];
	a_g0_rsv_zero: assert property (i_rd && i_addr == `SCG_ADDR_GATE_0 |=> (o_rdata & ~`SCG_G0_MASK) == 8'h00)
		else $error("reserved gate0 bit read as one");
	a_g1_rsv_zero: assert property (i_rd && i_addr == `SCG_ADDR_GATE_1 |=> (o_rdata & ~`SCG_G1_MASK) == 8'h00)
		else $error("reserved gate1 bit read as one");
	a_no_allow: assert property (i_sleep_instr && !ctrl_reg[0] && !o_sleeping |=> !o_sleeping)
		else $error("sleep entered without allow");
	a_sleep_enter: assert property (i_sleep_instr && ctrl_reg[0] && sel[2:1] != 2'h2 && !o_sleeping |=> o_sleeping && !o_core_clk_en)
		else $error("sleep not entered");
	a_idle_domains: assert property ($rose(o_sleeping) && sel == `SCG_MODE_IDLE |-> dom == 3'h7)
		else $error("idle domains wrong");
	a_quiet_domains: assert property ($rose(o_sleeping) && sel == `SCG_MODE_QUIET |-> dom == 3'h3)
		else $error("quiet domains wrong");
	a_down_domains: assert property ($rose(o_sleeping) && sel[2:1] == 2'h1 |-> dom == 3'h0)
		else $error("power down domains wrong");
	a_standby_osc: assert property ($rose(o_sleeping) && sel[2:1] == 2'h3 && i_crystal_src |-> dom == 3'h1)
		else $error("standby domains wrong");
	a_comp_auto_off: assert property ($rose(o_sleeping) && sel[2:1] != 2'h0 |-> !o_comparator_en)
		else $error("comparator left on in deep sleep");
	a_analog_kept: assert property ($rose(o_sleeping) |-> $stable(o_converter_en) && $stable(o_int_ref_en))
		else $error("converter or reference changed on sleep");
	a_usb_wake: assert property (o_sleeping && !o_core_clk_en && (i_usb_wake_irq || i_bus_voltage_change_irq) |-> ##[1:8] o_core_clk_en)
		else $error("usb wake ignored");
	a_mux_deny: assert property (i_wr && i_addr == `SCG_ADDR_GATE_0 |=> ##1 o_comparator_mux_ok == !$past(i_wdata[0], 2))
		else $error("comparator mux access wrong");
	a_usb_gate: assert property (i_wr && i_addr == `SCG_ADDR_GATE_1 && !o_sleeping |=> ##1 o_gate1_clk_en[7] == !$past(i_wdata[7], 2))
		else $error("usb clock gate wrong");
	c_xstby: cover property ($rose(o_sleeping) && sel == `SCG_MODE_XSTBY);
	c_resume: cover property ($rose(o_core_clk_en));
	c_read_g1: cover property (i_rd && i_addr == `SCG_ADDR_GATE_1);
endmodule
bind scg_sleep_gate scg_checker u_chk (.i_ref_clk, .i_srst, .i_wr, .i_rd, .i_sleep_instr,
	.i_crystal_src, .i_usb_wake_irq, .i_bus_voltage_change_irq, .o_sleeping, .o_core_clk_en,
	.o_io_clk_en, .o_converter_clk_en, .o_main_osc_en, .o_converter_en, .o_comparator_en,
	.o_comparator_mux_ok, .o_int_ref_en, .i_addr, .i_wdata, .o_rdata, .o_gate1_clk_en);
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the sleep and clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.vh"
module tb;
	localparam logic [1:0] A_CT = `SCG_ADDR_SLEEP_CTRL;
	localparam logic [1:0] A_G0 = `SCG_ADDR_GATE_0;
	localparam logic [1:0] A_G1 = `SCG_ADDR_GATE_1;
	localparam logic [1:0] A_AN = `SCG_ADDR_ANALOG_CTRL;
	logic i_ref_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_sleep_instr = 1'b0;
	logic i_crystal_src = 1'b1, i_wk_ext_lines_low = 1'b0, i_wk_ext_line_six = 1'b0;
	logic i_ext_line_six_level = 1'b0, i_wk_pin_change = 1'b0, i_wk_two_wire_match = 1'b0;
	logic i_wk_mem_ready = 1'b0, i_wk_converter = 1'b0, i_wk_watch_timer = 1'b0;
	logic i_wk_other_io = 1'b0, i_wk_usb_sync = 1'b0, i_bus_voltage_change_irq = 1'b0;
	logic i_usb_wake_irq = 1'b0;
	logic [1:0] i_addr = 2'h0;
	logic [7:0] i_wdata = 8'h00;
	wire [7:0] o_rdata, o_gate0_clk_en, o_gate1_clk_en;
	wire o_sleeping, o_core_clk_en, o_io_clk_en, o_converter_clk_en, o_main_osc_en;
	wire o_converter_en, o_converter_extended, o_comparator_en, o_comparator_mux_ok, o_int_ref_en;
	int errors = 0, n_checks = 0, cycles = 0, n;
	scg_sleep_gate uut (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_sleep_instr, .i_crystal_src, .i_wk_ext_lines_low, .i_wk_ext_line_six,
		.i_ext_line_six_level, .i_wk_pin_change, .i_wk_two_wire_match, .i_wk_mem_ready,
		.i_wk_converter, .i_wk_watch_timer, .i_wk_other_io, .i_wk_usb_sync,
		.i_bus_voltage_change_irq, .i_usb_wake_irq, .o_sleeping, .o_core_clk_en, .o_io_clk_en,
		.o_converter_clk_en, .o_main_osc_en, .o_gate0_clk_en, .o_gate1_clk_en, .o_converter_en,
		.o_converter_extended, .o_comparator_en, .o_comparator_mux_ok, .o_int_ref_en);
	always #10 i_ref_clk = ~i_ref_clk;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task close_out;
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			close_out;
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	localparam int S_SLP = 0;
	localparam int S_LOW = 1;
	localparam int S_SIX = 2;
	localparam int S_OIO = 3;
	localparam int S_VB = 4;
	localparam int S_UW = 5;
	localparam int S_PC = 6;
	localparam int S_CV = 7;
	localparam int S_TW = 8;
	localparam int S_MR = 9;
	localparam int S_WT = 10;
	localparam int S_US = 11;
	task set_line(input int s, input logic v);
		case (s)
			S_SLP: i_sleep_instr <= v;
			S_LOW: i_wk_ext_lines_low <= v;
			S_SIX: i_wk_ext_line_six <= v;
			S_OIO: i_wk_other_io <= v;
			S_VB: i_bus_voltage_change_irq <= v;
			S_UW: i_usb_wake_irq <= v;
			S_PC: i_wk_pin_change <= v;
			S_CV: i_wk_converter <= v;
			S_TW: i_wk_two_wire_match <= v;
			S_MR: i_wk_mem_ready <= v;
			S_WT: i_wk_watch_timer <= v;
			default: i_wk_usb_sync <= v;
		endcase
	endtask
	task pulse(input int s);
		@(posedge i_ref_clk) set_line(s, 1'b1);
		@(posedge i_ref_clk) set_line(s, 1'b0);
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_ref_clk) i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk) i_wr <= 1'b0;
	endtask
	task rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk) i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk) i_rd <= 1'b0;
		@(negedge i_ref_clk) chk(o_rdata, exp);
	endtask
	task enter(input logic [7:0] c, input logic e);
		wr(A_CT, c);
		pulse(S_SLP);
		@(negedge i_ref_clk) chk(o_sleeping, e);
	endtask
	task wake(input int s);
		pulse(s);
		@(negedge i_ref_clk) n = 0;
		while (!o_core_clk_en && n < 20) begin
			@(negedge i_ref_clk) n++;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rd(A_G0, 8'h00);
		rd(A_G1, 8'h00);
		wr(A_G0, 8'hff);
		wr(A_G1, 8'hff);
		rd(A_G0, `SCG_G0_MASK);
		rd(A_G1, `SCG_G1_MASK);
		chk(o_gate0_clk_en, 8'h00);
		chk(o_comparator_mux_ok, 1'b0);
		wr(A_G0, 8'h00);
		wr(A_G1, 8'h00);
		repeat (2) @(negedge i_ref_clk);
		chk(o_gate0_clk_en, `SCG_G0_MASK);
		chk(o_gate1_clk_en, `SCG_G1_MASK);
	endtask
	task t_refuse;
		enter(8'h04, 1'b0);
		enter(8'h09, 1'b0);
		enter(8'h0b, 1'b0);
	endtask
	task t_modes;
		logic [17:0] codes;
		logic [17:0] doms;
		codes = 18'h3e688;
		doms = 18'h0901f;
		for (int k = 0; k < 6; k++) begin
			enter({4'h0, codes[k*3 +: 3], 1'b1}, 1'b1);
			chk({o_core_clk_en, o_io_clk_en, o_converter_clk_en, o_main_osc_en}, doms[k*3 +: 3]);
			wake(S_LOW);
			chk({n >= 5, n < 12}, {codes[k*3+2], 1'b1});
		end
	endtask
	task t_wake;
		enter(8'h05, 1'b1);
		chk(o_gate0_clk_en, 8'h00);
		pulse(S_OIO);
		pulse(S_SIX);
		pulse(S_MR);
		@(negedge i_ref_clk) chk(o_sleeping, 1'b1);
		@(posedge i_ref_clk) i_ext_line_six_level <= 1'b1;
		wake(S_SIX);
		chk(n < 3, 1'b1);
		enter(8'h05, 1'b1);
		wake(S_VB);
		chk(n < 3, 1'b1);
		enter(8'h07, 1'b1);
		wake(S_TW);
		chk(n < 3, 1'b1);
		enter(8'h0d, 1'b1);
		wake(S_WT);
		chk(n >= 5 && n < 12, 1'b1);
		enter(8'h0f, 1'b1);
		wake(S_UW);
		chk(n < 12, 1'b1);
		enter(8'h03, 1'b1);
		wake(S_US);
		chk(n < 3, 1'b1);
		enter(8'h01, 1'b1);
		chk(o_gate0_clk_en, `SCG_G0_MASK);
		wake(S_OIO);
		chk(n < 3, 1'b1);
	endtask
	task t_analog;
		wr(A_AN, 8'h07);
		@(negedge i_ref_clk) chk(o_converter_extended, 1'b1);
		pulse(S_CV);
		repeat (2) @(negedge i_ref_clk);
		chk(o_converter_extended, 1'b0);
		wr(A_AN, 8'h06);
		wr(A_AN, 8'h07);
		@(negedge i_ref_clk) chk(o_converter_extended, 1'b1);
		enter(8'h05, 1'b1);
		chk({o_converter_en, o_comparator_en, o_int_ref_en}, 3'h5);
		wake(S_PC);
		enter(8'h01, 1'b1);
		chk(o_comparator_en, 1'b1);
		wake(S_LOW);
	endtask
	initial begin
		repeat (12) @(posedge i_ref_clk);
		i_srst <= 1'b0;
		t_regs;
		t_refuse;
		t_modes;
		t_wake;
		t_analog;
		close_out;
	end
endmodule
`default_nettype wire
